/* rtl/imsc_ctrl.sv */
// Notes on behaviour
// R1: in-service priority readable, writes ignored
// R2: macro service runs during nonmaskable handler
// R3: set mask flag suppresses that macro service
// R4: only interrupt return releases nonmaskable nesting
// R5: nonmaskable accepted except nesting and special window
// R6: nonmaskable accept pushes at current stack pointer
// R7: vectored maskable ends by interrupt return
// R8: context switch ends by context return
// R9: interrupt return after break leaves priorities
// R10: break context return never clears priority bit
// R11: serial transmit macro end raises two requests
// R12: block transfer buffers, pointer at even addresses
// R13: difference mode count never programmed zero
// R14: previous sample preloaded before difference mode
// R15: difference mode reaches 16-bit peripheral registers
// R16: self-branching bit test holds all services
// R17: halt refused on unmasked request, waits macro
// R18: accept sets level bit, return clears highest
//
// The address map and the address-and-strobe port were left to the implementer.
module imsc_ctrl (
  input logic ref_clk,
  input logic rst_n,
  input logic [imsc_pkg::AW-1:0] reg_addr,
  input logic [imsc_pkg::DW-1:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [imsc_pkg::DW-1:0] reg_rdata,
  input logic [imsc_pkg::N_SRC-1:0] src_req,
  input logic nmi_lo_in,
  input logic nmi_hi_in,
  input logic instr_done,
  input imsc_pkg::imsc_instr_t instr_kind,
  input logic [15:0] sp_val,
  input logic seq_ack,
  input logic ms_done,
  input logic halt_req,
  output logic vec_req,
  output logic [imsc_pkg::SRC_W-1:0] vec_src,
  output logic vec_cs,
  output logic nmi_req,
  output logic nmi_hi_sel,
  output logic push_req,
  output logic [15:0] push_addr,
  output logic bank_restore,
  output logic ms_req,
  output logic [imsc_pkg::SRC_W-1:0] ms_src,
  output logic [1:0] ms_mode,
  output logic [15:0] ms_ptr,
  output logic [7:0] ms_count,
  output logic ms_word,
  output logic halt_enter,
  output logic irq
);
  import imsc_pkg::*;

  typedef struct packed {
    imsc_state_t st;
    logic [N_SRC-1:0] req;
    logic [N_SRC-1:0] mask;
    logic [N_SRC-1:0] msel;
    logic [N_SRC-1:0] cssel;
    logic [2*N_SRC-1:0] prio;
    logic [N_LVL-1:0] in_service_priority_reg;
    logic [N_EV-1:0] status;
    logic [N_EV-1:0] irq_mask;
    logic [N_SRC-1:0][7:0] cnt;
    logic [N_SRC-1:0][1:0] mode;
    logic [N_SRC-1:0][15:0] ptr;
    imsc_kind_t [KS_DEPTH-1:0] kstack;
    logic [3:0] ksp;
    logic nmi_lo_pend;
    logic nmi_hi_pend;
    logic nmi_lo_svc;
    logic nmi_hi_svc;
    logic hold;
    logic [WIN_W-1:0] win;
    logic halt_pend;
    logic vec_req;
    logic [SRC_W-1:0] vec_src;
    logic vec_cs;
    logic nmi_req;
    logic nmi_hi_sel;
    logic push_req;
    logic [15:0] push_addr;
    logic bank_restore;
    logic ms_req;
    logic [SRC_W-1:0] ms_src;
    logic [1:0] ms_mode;
    logic [15:0] ms_ptr;
    logic [7:0] ms_count;
    logic ms_word;
    logic halt_enter;
    logic irq;
    logic [DW-1:0] rd_data;
  } imsc_regs_t;

  imsc_regs_t s_reg;
  imsc_regs_t s_next;
  imsc_pick_if pk ();

  imsc_prio_pick u_pick (
    .p(pk.resolver)
  );

  assign pk.req = s_reg.req;
  assign pk.mask = s_reg.mask;
  assign pk.msel = s_reg.msel;
  assign pk.prio = s_reg.prio;
  assign pk.in_service_priority_reg = s_reg.in_service_priority_reg;

  logic nmi_go_hi;
  logic nmi_go_lo;
  logic grant_ok;
  logic [2:0] top_idx;
  imsc_kind_t top_kind;

  // a low level request may not nest inside either handler
  assign nmi_go_hi = s_reg.nmi_hi_pend && !s_reg.nmi_hi_svc; // R5
  assign nmi_go_lo = s_reg.nmi_lo_pend && !s_reg.nmi_lo_svc &&
                     !s_reg.nmi_hi_svc; // R5
  // grants only between instruction retirements keep the stack single-push
  assign grant_ok = !s_reg.hold && !instr_done; // R16
  assign top_idx = 3'(s_reg.ksp - 4'h1);
  assign top_kind = s_reg.kstack[top_idx];

  always_comb begin
    logic [N_EV-1:0] ev;
    logic [N_EV-1:0] st_clr;
    logic push_en;
    imsc_kind_t push_kind;
    logic pop_en;
    logic [SRC_W-1:0] src;
    logic [7:0] cnt_dec;
    logic vec_pend;
    logic ms_pend;
    ev = '0;
    st_clr = '0;
    push_en = 1'b0;
    push_kind = K_VEC;
    pop_en = 1'b0;
    src = s_reg.ms_src;
    cnt_dec = s_reg.cnt[src] - 8'h01;
    vec_pend = |(s_reg.req & ~s_reg.mask & ~s_reg.msel);
    ms_pend = |(s_reg.req & ~s_reg.mask & s_reg.msel) ||
              (s_reg.st == ST_MS);
    s_next = s_reg;
    s_next.bank_restore = 1'b0;
    s_next.rd_data = '0;
    if (s_reg.win != '0) begin
      s_next.win = s_reg.win - WIN_W'(1);
    end

    if (reg_wr) begin
      if (reg_addr[AW-1:3] == PAGE_MS_CFG) begin
        s_next.cnt[reg_addr[2:0]] = reg_wdata[CFG_CNT_LSB +: 8];
        s_next.mode[reg_addr[2:0]] = reg_wdata[CFG_MODE_LSB +: 2];
      end else if (reg_addr[AW-1:3] == PAGE_MS_PTR) begin
        s_next.ptr[reg_addr[2:0]] = reg_wdata;
      end else begin
        case (reg_addr)
          OFF_REQ: s_next.req = s_reg.req & ~reg_wdata[N_SRC-1:0];
          OFF_MASK: s_next.mask = reg_wdata[N_SRC-1:0];
          OFF_MSEL: s_next.msel = reg_wdata[N_SRC-1:0];
          OFF_CSSEL: s_next.cssel = reg_wdata[N_SRC-1:0];
          OFF_PRIO: s_next.prio = reg_wdata;
          OFF_INSV: ev[EV_WR_ERR] = 1'b1; // R1
          OFF_IRQ_MASK: s_next.irq_mask = reg_wdata[N_EV-1:0];
          default: ;
        endcase
      end
    end
    if (reg_rd) begin
      if (reg_addr[AW-1:3] == PAGE_MS_CFG) begin
        s_next.rd_data = {6'h00, s_reg.mode[reg_addr[2:0]],
                          s_reg.cnt[reg_addr[2:0]]};
      end else if (reg_addr[AW-1:3] == PAGE_MS_PTR) begin
        s_next.rd_data = s_reg.ptr[reg_addr[2:0]];
      end else begin
        case (reg_addr)
          OFF_REQ: s_next.rd_data = {8'h00, s_reg.req};
          OFF_MASK: s_next.rd_data = {8'h00, s_reg.mask};
          OFF_MSEL: s_next.rd_data = {8'h00, s_reg.msel};
          OFF_CSSEL: s_next.rd_data = {8'h00, s_reg.cssel};
          OFF_PRIO: s_next.rd_data = s_reg.prio;
          OFF_INSV: s_next.rd_data = {12'h000, s_reg.in_service_priority_reg}; // R1
          OFF_IRQ_ST: begin
            s_next.rd_data = {10'h000, s_reg.status};
            st_clr = '1;
          end
          OFF_IRQ_MASK: s_next.rd_data = {10'h000, s_reg.irq_mask};
          default: ;
        endcase
      end
    end

    if (instr_done) begin
      s_next.hold = (instr_kind == IK_BTC_SELF); // R16
      case (instr_kind)
        IK_SPECIAL: s_next.win = SPECIAL_WIN_CYC; // R5
        IK_SWB: begin
          push_en = 1'b1;
          push_kind = K_SWB;
        end
        IK_SWBCS: begin
          push_en = 1'b1;
          push_kind = K_SWBCS;
        end
        IK_IRET, IK_CSRET, IK_BCSRET: begin
          pop_en = (s_reg.ksp != 4'h0);
          ev[EV_RET_ERR] = !pop_en;
          if (pop_en && instr_kind == IK_IRET) begin
            if (top_kind == K_VEC) begin
              s_next.in_service_priority_reg = s_reg.in_service_priority_reg & (s_reg.in_service_priority_reg - 4'h1); // R7 R18
            end else if (top_kind == K_NMI_HI) begin
              s_next.nmi_hi_svc = 1'b0; // R4
            end else if (top_kind == K_NMI_LO) begin
              s_next.nmi_lo_svc = 1'b0; // R4
            end else if (top_kind != K_SWB) begin
              ev[EV_RET_ERR] = 1'b1; // R9
            end
          end else if (pop_en && instr_kind == IK_CSRET) begin
            if (top_kind == K_CS) begin
              s_next.in_service_priority_reg = s_reg.in_service_priority_reg & (s_reg.in_service_priority_reg - 4'h1); // R8
              s_next.bank_restore = 1'b1; // R8
            end else begin
              ev[EV_RET_ERR] = 1'b1;
            end
          end else if (pop_en) begin
            s_next.bank_restore = (top_kind == K_SWBCS); // R10
            ev[EV_RET_ERR] = (top_kind != K_SWBCS);
          end
        end
        default: ;
      endcase
    end

    unique case (s_reg.st)
      ST_IDLE: begin
        if (grant_ok && s_reg.win == '0 && (nmi_go_hi || nmi_go_lo)) begin
          s_next.st = ST_NMI; // R5
          s_next.nmi_req = 1'b1;
          s_next.nmi_hi_sel = nmi_go_hi;
          s_next.push_req = 1'b1;
          s_next.push_addr = sp_val; // R6
          push_en = 1'b1;
          push_kind = nmi_go_hi ? K_NMI_HI : K_NMI_LO;
          if (nmi_go_hi) begin
            s_next.nmi_hi_pend = 1'b0;
            s_next.nmi_hi_svc = 1'b1;
          end else begin
            s_next.nmi_lo_pend = 1'b0;
            s_next.nmi_lo_svc = 1'b1;
          end
          ev[EV_NMI] = 1'b1;
        end else if (grant_ok && pk.ms_ok) begin
          // nonmaskable service state is not consulted here
          s_next.st = ST_MS; // R2 R3
          s_next.ms_req = 1'b1;
          s_next.ms_src = pk.ms_src;
          s_next.ms_mode = s_reg.mode[pk.ms_src];
          s_next.ms_ptr = s_reg.ptr[pk.ms_src];
          s_next.ms_count = s_reg.cnt[pk.ms_src];
          s_next.ms_word = s_reg.mode[pk.ms_src][MD_DIFF_BIT]; // R15
          s_next.req[pk.ms_src] = 1'b0;
        end else if (grant_ok && pk.vec_ok &&
                     !s_reg.nmi_lo_svc && !s_reg.nmi_hi_svc) begin
          s_next.st = ST_VEC;
          s_next.vec_req = 1'b1;
          s_next.vec_src = pk.vec_src;
          s_next.vec_cs = s_reg.cssel[pk.vec_src];
          s_next.push_req = !s_reg.cssel[pk.vec_src];
          s_next.push_addr = sp_val;
          s_next.req[pk.vec_src] = 1'b0;
          s_next.in_service_priority_reg[s_reg.prio[2*pk.vec_src +: 2]] = 1'b1; // R18
          push_en = 1'b1;
          push_kind = s_reg.cssel[pk.vec_src] ? K_CS : K_VEC;
          ev[EV_VEC] = 1'b1;
        end
      end
      ST_VEC, ST_NMI: begin
        if (seq_ack) begin
          s_next.st = ST_IDLE;
          s_next.vec_req = 1'b0;
          s_next.nmi_req = 1'b0;
          s_next.push_req = 1'b0;
        end
      end
      ST_MS: begin
        if (ms_done) begin
          s_next.st = ST_IDLE;
          s_next.ms_req = 1'b0;
          s_next.ptr[src] = s_reg.ptr[src] + 16'h0001;
          s_next.cnt[src] = cnt_dec;
          // a zero count ends at once rather than wrapping to 255
          if (s_reg.cnt[src] == 8'h00 || cnt_dec == 8'h00) begin // R13
            s_next.cnt[src] = 8'h00;
            s_next.msel[src] = 1'b0;
            s_next.req[src] = 1'b1;
            if (src == UART_TX_SRC) begin
              s_next.req[UART_TX_PAIR_SRC] = 1'b1; // R11
            end
            ev[EV_MS_END] = 1'b1;
          end
        end
      end
    endcase

    if (s_reg.halt_pend) begin
      if (vec_pend) begin
        s_next.halt_pend = 1'b0; // R17
        ev[EV_HALT_REF] = 1'b1;
      end else if (!ms_pend && !s_reg.nmi_lo_pend &&
                   !s_reg.nmi_hi_pend) begin
        s_next.halt_pend = 1'b0; // R17
        s_next.halt_enter = 1'b1;
      end
    end
    // a new request in the deciding cycle must not be lost
    if (halt_req) begin
      s_next.halt_pend = 1'b1;
    end
    if (s_reg.halt_enter && (vec_pend || ms_pend ||
                             s_reg.nmi_lo_pend || s_reg.nmi_hi_pend)) begin
      s_next.halt_enter = 1'b0;
    end

    if (pop_en) begin
      s_next.ksp = s_reg.ksp - 4'h1;
    end
    // overflow beyond the stack depth is dropped silently
    if (push_en && s_reg.ksp != 4'(KS_DEPTH)) begin
      s_next.kstack[s_reg.ksp[2:0]] = push_kind;
      s_next.ksp = s_reg.ksp + 4'h1;
    end
    s_next.req = s_next.req | src_req;
    s_next.nmi_lo_pend = s_next.nmi_lo_pend | nmi_lo_in;
    s_next.nmi_hi_pend = s_next.nmi_hi_pend | nmi_hi_in;
    s_next.status = (s_reg.status & ~st_clr) | ev;
    s_next.irq = |(s_next.status & s_next.irq_mask);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.mask <= RST_MASK;
      s_reg.prio <= RST_PRIO;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rd_data;
  assign vec_req = s_reg.vec_req;
  assign vec_src = s_reg.vec_src;
  assign vec_cs = s_reg.vec_cs;
  assign nmi_req = s_reg.nmi_req;
  assign nmi_hi_sel = s_reg.nmi_hi_sel;
  assign push_req = s_reg.push_req;
  assign push_addr = s_reg.push_addr;
  assign bank_restore = s_reg.bank_restore;
  assign ms_req = s_reg.ms_req;
  assign ms_src = s_reg.ms_src;
  assign ms_mode = s_reg.ms_mode;
  assign ms_ptr = s_reg.ms_ptr;
  assign ms_count = s_reg.ms_count;
  assign ms_word = s_reg.ms_word;
  assign halt_enter = s_reg.halt_enter;
  assign irq = s_reg.irq;

  logic [1:0] vec_lvl;
  assign vec_lvl = s_reg.prio[2*s_reg.vec_src +: 2];
  // level of the source being granted, before vec_src moves
  logic [1:0] grant_lvl;
  assign grant_lvl = s_reg.prio[2*pk.vec_src +: 2];

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  property p_insv_ro;
    reg_wr && reg_addr == OFF_INSV |=> s_reg.status[EV_WR_ERR];
  endproperty
  a_insv_ro: assert property (p_insv_ro) // R1
    else $error("write to in-service register not flagged");

  property p_ms_in_nmi;
    s_reg.st == ST_IDLE && pk.ms_ok && grant_ok && s_reg.nmi_lo_svc &&
    !(s_reg.win == '0 && (nmi_go_hi || nmi_go_lo)) |=> ms_req;
  endproperty
  a_ms_in_nmi: assert property (p_ms_in_nmi) // R2
    else $error("macro service blocked during nonmaskable handler");

  property p_ms_unmasked;
    $rose(ms_req) |-> !$past(s_reg.mask[pk.ms_src]);
  endproperty
  a_ms_unmasked: assert property (p_ms_unmasked) // R3
    else $error("macro service started for masked source");

  property p_nmi_release;
    $fell(s_reg.nmi_hi_svc) || $fell(s_reg.nmi_lo_svc) |->
      $past(instr_done && instr_kind == IK_IRET);
  endproperty
  a_nmi_release: assert property (p_nmi_release) // R4
    else $error("nonmaskable nesting released without return");

  property p_nmi_window;
    $rose(nmi_req) |-> $past(s_reg.win) == '0 && !$past(s_reg.hold);
  endproperty
  a_nmi_window: assert property (p_nmi_window) // R5
    else $error("nonmaskable accepted inside blocked window");

  property p_nmi_push;
    $rose(nmi_req) |-> push_req && push_addr == $past(sp_val);
  endproperty
  a_nmi_push: assert property (p_nmi_push) // R6
    else $error("nonmaskable accept without push at stack pointer");

  property p_vec_level;
    $rose(vec_req) |-> s_reg.in_service_priority_reg[vec_lvl] && !$past(s_reg.in_service_priority_reg[grant_lvl]);
  endproperty
  a_vec_level: assert property (p_vec_level) // R18
    else $error("vectored accept did not set its level bit");

  property p_bank_restore;
    bank_restore |-> $past(instr_done) &&
      ($past(instr_kind) == IK_CSRET || $past(instr_kind) == IK_BCSRET);
  endproperty
  a_bank_restore: assert property (p_bank_restore) // R8
    else $error("bank restore without context return");

  property p_swb_iret;
    instr_done && instr_kind == IK_IRET && s_reg.ksp != 4'h0 &&
    top_kind == K_SWB |=> $stable(s_reg.in_service_priority_reg);
  endproperty
  a_swb_iret: assert property (p_swb_iret) // R9
    else $error("return from break altered in-service bits");

  property p_swbcs_ret;
    instr_done && instr_kind == IK_BCSRET |=> $stable(s_reg.in_service_priority_reg);
  endproperty
  a_swbcs_ret: assert property (p_swbcs_ret) // R10
    else $error("break context return changed in-service bits");

  property p_diff_word;
    ms_req && ms_mode[MD_DIFF_BIT] |-> ms_word;
  endproperty
  a_diff_word: assert property (p_diff_word) // R15
    else $error("difference mode issued byte access");

  property p_hold;
    s_reg.hold && s_reg.st == ST_IDLE |=> s_reg.st == ST_IDLE;
  endproperty
  a_hold: assert property (p_hold) // R16
    else $error("service granted during self branch");

  property p_halt;
    $rose(halt_enter) |-> $past(s_reg.st) != ST_MS &&
      $past(s_reg.req & ~s_reg.mask) == '0;
  endproperty
  a_halt: assert property (p_halt) // R17
    else $error("halt entered with unmasked request pending");

  c_nmi_nest: cover property (s_reg.nmi_lo_svc && $rose(s_reg.nmi_hi_svc));
  c_ms_end: cover property ($rose(s_reg.status[EV_MS_END]));
  c_halt: cover property ($rose(halt_enter));
  c_vec_cs: cover property ($rose(vec_req) && vec_cs);
endmodule

/* rtl/imsc_pick_if.sv */
interface imsc_pick_if;
  logic [imsc_pkg::N_SRC-1:0] req;
  logic [imsc_pkg::N_SRC-1:0] mask;
  logic [imsc_pkg::N_SRC-1:0] msel;
  logic [2*imsc_pkg::N_SRC-1:0] prio;
  logic [imsc_pkg::N_LVL-1:0] in_service_priority_reg;
  logic vec_ok;
  logic [imsc_pkg::SRC_W-1:0] vec_src;
  logic ms_ok;
  logic [imsc_pkg::SRC_W-1:0] ms_src;
  modport resolver (input req, mask, msel, prio, in_service_priority_reg,
                    output vec_ok, vec_src, ms_ok, ms_src);
  modport ctrl (output req, mask, msel, prio, in_service_priority_reg,
                input vec_ok, vec_src, ms_ok, ms_src);
endinterface

/* rtl/imsc_pkg.sv */
package imsc_pkg;
  localparam int N_SRC = 8;
  localparam int SRC_W = 3;
  localparam int DW = 16;
  localparam int AW = 6;
  localparam int N_LVL = 4;
  localparam int N_EV = 6;
  localparam int KS_DEPTH = 8;

  localparam logic [AW-1:0] OFF_REQ = 6'h00;
  localparam logic [AW-1:0] OFF_MASK = 6'h01;
  localparam logic [AW-1:0] OFF_MSEL = 6'h02;
  localparam logic [AW-1:0] OFF_CSSEL = 6'h03;
  localparam logic [AW-1:0] OFF_PRIO = 6'h04;
  localparam logic [AW-1:0] OFF_INSV = 6'h05;
  localparam logic [AW-1:0] OFF_IRQ_ST = 6'h06;
  localparam logic [AW-1:0] OFF_IRQ_MASK = 6'h07;
  localparam logic [2:0] PAGE_MS_CFG = 3'h2;
  localparam logic [2:0] PAGE_MS_PTR = 3'h3;
  localparam int CFG_CNT_LSB = 0;
  localparam int CFG_MODE_LSB = 8;

  localparam logic [N_SRC-1:0] RST_MASK = 8'hff;
  localparam logic [2*N_SRC-1:0] RST_PRIO = 16'hffff;

  localparam logic [1:0] MD_BLOCK = 2'h0;
  localparam logic [1:0] MD_BLOCK_PTR = 2'h1;
  localparam logic [1:0] MD_DIFF = 2'h2;
  localparam logic [1:0] MD_DIFF_PTR = 2'h3;
  localparam int MD_DIFF_BIT = 1;

  localparam int EV_VEC = 0;
  localparam int EV_NMI = 1;
  localparam int EV_MS_END = 2;
  localparam int EV_RET_ERR = 3;
  localparam int EV_WR_ERR = 4;
  localparam int EV_HALT_REF = 5;

  localparam logic [SRC_W-1:0] UART_TX_SRC = 3'h3;
  localparam logic [SRC_W-1:0] UART_TX_PAIR_SRC = 3'h4;

  localparam int CLK_PERIOD_NS = 8;
  localparam int SPECIAL_WIN_NS = 16;
  localparam int WIN_W = 3;
  localparam logic [WIN_W-1:0] SPECIAL_WIN_CYC =
    WIN_W'((SPECIAL_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    IK_OTHER = 3'b000,
    IK_IRET = 3'b001,
    IK_CSRET = 3'b010,
    IK_BCSRET = 3'b011,
    IK_SWB = 3'b100,
    IK_SWBCS = 3'b101,
    IK_BTC_SELF = 3'b110,
    IK_SPECIAL = 3'b111
  } imsc_instr_t;

  typedef enum logic [2:0] {
    K_VEC = 3'b000,
    K_CS = 3'b001,
    K_NMI_LO = 3'b010,
    K_NMI_HI = 3'b011,
    K_SWB = 3'b100,
    K_SWBCS = 3'b101
  } imsc_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_VEC = 2'b01,
    ST_NMI = 2'b10,
    ST_MS = 2'b11
  } imsc_state_t;
endpackage

/* rtl/imsc_prio_pick.sv */
module imsc_prio_pick (
  imsc_pick_if.resolver p
);
  import imsc_pkg::*;

  logic [N_SRC-1:0] vec_el;
  logic [N_SRC-1:0] ms_el;
  logic [2:0] cur_lvl;

  function automatic logic [SRC_W:0] pick(input logic [N_SRC-1:0] el,
                                          input logic [2*N_SRC-1:0] pr);
    logic found;
    logic [SRC_W-1:0] src;
    logic [1:0] best;
    found = 1'b0;
    src = '0;
    best = 2'h3;
    // downward scan with <= leaves the lowest index on a tie
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (el[i] && (!found || pr[2*i +: 2] <= best)) begin
        found = 1'b1;
        src = SRC_W'(i);
        best = pr[2*i +: 2];
      end
    end
    return {found, src};
  endfunction

  always_comb begin
    cur_lvl = 3'h4;
    for (int l = N_LVL - 1; l >= 0; l--) begin
      if (p.in_service_priority_reg[l]) begin
        cur_lvl = 3'(l);
      end
    end
  end

  for (genvar i = 0; i < N_SRC; i++) begin : g_el
    assign vec_el[i] = p.req[i] & ~p.mask[i] & ~p.msel[i] &
                       ({1'b0, p.prio[2*i +: 2]} < cur_lvl);
    assign ms_el[i] = p.req[i] & ~p.mask[i] & p.msel[i];
  end

  assign {p.vec_ok, p.vec_src} = pick(vec_el, p.prio);
  assign {p.ms_ok, p.ms_src} = pick(ms_el, p.prio);
endmodule

/* tb/imsc_seq_model.sv */
module imsc_seq_model (
  input logic ref_clk,
  input logic rst_n,
  input logic [3:0] dly,
  input logic vec_req,
  input logic nmi_req,
  input logic ms_req,
  output logic seq_ack,
  output logic ms_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] a_cnt;
  logic [3:0] m_cnt;
  // skip the cycle of our own answer: the request is only dropping then
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      seq_ack <= 1'b0;
      ms_done <= 1'b0;
      a_cnt <= 4'h0;
      m_cnt <= 4'h0;
    end else begin
      seq_ack <= 1'b0;
      ms_done <= 1'b0;
      if ((vec_req || nmi_req) && !seq_ack) begin
        if (a_cnt >= dly) begin
          seq_ack <= 1'b1;
          a_cnt <= 4'h0;
        end else begin
          a_cnt <= a_cnt + 4'h1;
        end
      end
      if (ms_req && !ms_done) begin
        if (m_cnt >= dly) begin
          ms_done <= 1'b1;
          m_cnt <= 4'h0;
        end else begin
          m_cnt <= m_cnt + 4'h1;
        end
      end
    end
  end
endmodule

/* tb/tb_top.sv */
module tb_top;
  import imsc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [AW-1:0] reg_addr = 6'h00;
  logic [DW-1:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [N_SRC-1:0] src_req = 8'h00;
  logic nmi_lo_in = 1'b0;
  logic nmi_hi_in = 1'b0;
  logic instr_done = 1'b0;
  imsc_instr_t instr_kind = IK_OTHER;
  logic [15:0] sp_val = 16'h0000;
  logic halt_req = 1'b0;
  logic [3:0] dly = 4'h0;
  logic [DW-1:0] reg_rdata;
  logic vec_req, vec_cs, nmi_req, nmi_hi_sel, push_req, bank_restore;
  logic ms_req, ms_word, halt_enter, irq, seq_ack, ms_done;
  logic [SRC_W-1:0] vec_src, ms_src;
  logic [15:0] push_addr, ms_ptr;
  logic [1:0] ms_mode;
  logic [7:0] ms_count;
  logic [15:0] d;
  logic ok;
  int n_mismatch = 0;
  int compares = 0;

  imsc_ctrl i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .src_req(src_req), .nmi_lo_in(nmi_lo_in),
    .nmi_hi_in(nmi_hi_in), .instr_done(instr_done),
    .instr_kind(instr_kind), .sp_val(sp_val), .seq_ack(seq_ack),
    .ms_done(ms_done), .halt_req(halt_req), .vec_req(vec_req),
    .vec_src(vec_src), .vec_cs(vec_cs), .nmi_req(nmi_req),
    .nmi_hi_sel(nmi_hi_sel), .push_req(push_req), .push_addr(push_addr),
    .bank_restore(bank_restore), .ms_req(ms_req), .ms_src(ms_src),
    .ms_mode(ms_mode), .ms_ptr(ms_ptr), .ms_count(ms_count),
    .ms_word(ms_word), .halt_enter(halt_enter), .irq(irq));

  imsc_seq_model i_seq (.ref_clk(ref_clk), .rst_n(rst_n), .dly(dly),
    .vec_req(vec_req), .nmi_req(nmi_req), .ms_req(ms_req),
    .seq_ack(seq_ack), .ms_done(ms_done));

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic end_of_test;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // every task starts and ends just after a rising edge
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [AW-1:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask

  task automatic src(input int i);
    src_req[i] <= 1'b1;
    @(posedge ref_clk);
    src_req <= 8'h00;
  endtask

  task automatic nmi(input logic hi);
    nmi_lo_in <= !hi;
    nmi_hi_in <= hi;
    @(posedge ref_clk);
    nmi_lo_in <= 1'b0;
    nmi_hi_in <= 1'b0;
  endtask

  task automatic instr(input imsc_instr_t k);
    @(posedge ref_clk);
    instr_kind <= k;
    instr_done <= 1'b1;
    @(posedge ref_clk);
    instr_done <= 1'b0;
  endtask

  task automatic halt;
    halt_req <= 1'b1;
    @(posedge ref_clk);
    halt_req <= 1'b0;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return vec_req;
      1: return nmi_req;
      2: return ms_req;
      3: return halt_enter;
      default: return bank_restore;
    endcase
  endfunction

  // values read at the edge are those of the cycle just ended
  task automatic wait_for(input int s, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      if (pick(s)) break;
    end
    ok = pick(s);
  endtask

  task automatic t_reset;
    rd(OFF_MASK);
    chk(d, {8'h00, RST_MASK});
    rd(OFF_PRIO);
    chk(d, RST_PRIO);
    rd(6'h3f);
    chk(d, 16'h0000);
    wr(OFF_IRQ_MASK, 16'h0010);
    wr(OFF_INSV, 16'h000f);
    rd(OFF_INSV);
    chk(d, 16'h0000);
    chk(irq, 1'b1);
    rd(OFF_IRQ_ST);
    chk(d[EV_WR_ERR], 1'b1);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1'b0);
  endtask

  task automatic t_vec;
    sp_val <= 16'h1234;
    wr(OFF_PRIO, 16'hfffc);
    wr(OFF_MASK, 16'h00fe);
    src(0);
    wait_for(0, 20);
    chk(ok, 1'b1);
    chk(vec_src, 3'h0);
    chk(push_addr, 16'h1234);
    rd(OFF_INSV);
    chk(d, 16'h0001);
    instr(IK_SWB);
    instr(IK_IRET);
    rd(OFF_INSV);
    chk(d, 16'h0001);
    instr(IK_SWBCS);
    instr(IK_BCSRET);
    wait_for(4, 3);
    chk(ok, 1'b1);
    rd(OFF_INSV);
    chk(d, 16'h0001);
    instr(IK_IRET);
    rd(OFF_INSV);
    chk(d, 16'h0000);
    rd(OFF_IRQ_ST);
    chk(d[EV_RET_ERR], 1'b0);
  endtask

  task automatic t_cs;
    wr(OFF_CSSEL, 16'h0002);
    wr(OFF_PRIO, 16'hfff0);
    wr(OFF_MASK, 16'h00fc);
    src(1);
    wait_for(0, 20);
    chk(vec_cs, 1'b1);
    chk(push_req, 1'b0);
    rd(OFF_INSV);
    chk(d, 16'h0001);
    instr(IK_CSRET);
    wait_for(4, 3);
    chk(ok, 1'b1);
    rd(OFF_INSV);
    chk(d, 16'h0000);
  endtask

  task automatic t_nmi;
    dly <= 4'h4;
    sp_val <= 16'hffff;
    nmi(1'b0);
    wait_for(1, 20);
    chk(ok, 1'b1);
    chk(push_req, 1'b1);
    chk(push_addr, 16'hffff);
    repeat (8) @(posedge ref_clk);
    nmi(1'b0);
    wait_for(1, 10);
    chk(ok, 1'b0);
    wr(6'h13, {6'h00, MD_DIFF, 8'h01});
    wr(6'h1b, 16'h0100);
    wr(OFF_MSEL, 16'h0008);
    wr(OFF_MASK, 16'h00f4);
    src(3);
    wait_for(2, 20);
    chk(ok, 1'b1);
    chk(ms_word, 1'b1);
    chk({ms_src, ms_mode, ms_count}, {UART_TX_SRC, MD_DIFF, 8'h01});
    chk(ms_ptr, 16'h0100);
    repeat (8) @(posedge ref_clk);
    rd(OFF_REQ);
    chk(d[4:3], 2'h3);
    rd(6'h1b);
    chk(d, 16'h0101);
    nmi(1'b1);
    wait_for(1, 20);
    chk(nmi_hi_sel, 1'b1);
    repeat (8) @(posedge ref_clk);
    instr(IK_IRET);
    wait_for(1, 8);
    chk(ok, 1'b0);
    instr(IK_IRET);
    wait_for(1, 10);
    chk(ok, 1'b1);
    repeat (8) @(posedge ref_clk);
    instr(IK_IRET);
    wait_for(0, 20);
    chk(vec_src, UART_TX_SRC);
    repeat (8) @(posedge ref_clk);
    instr(IK_IRET);
  endtask

  task automatic t_halt;
    dly <= 4'h0;
    wr(6'h15, {6'h00, MD_BLOCK, 8'h02});
    wr(OFF_MSEL, 16'h0020);
    src(5);
    wait_for(2, 10);
    chk(ok, 1'b0);
    halt();
    wait_for(3, 10);
    chk(ok, 1'b1);
    wr(OFF_MASK, 16'h00d4);
    wait_for(2, 10);
    chk(ok, 1'b1);
    repeat (4) @(posedge ref_clk);
    chk(halt_enter, 1'b0);
    instr(IK_BTC_SELF);
    src(0);
    wait_for(0, 10);
    chk(ok, 1'b0);
    halt();
    repeat (3) @(posedge ref_clk);
    rd(OFF_IRQ_ST);
    chk(d[EV_HALT_REF], 1'b1);
    chk(halt_enter, 1'b0);
    instr(IK_OTHER);
    wait_for(0, 10);
    chk(ok, 1'b1);
    repeat (4) @(posedge ref_clk);
    instr(IK_CSRET);
    rd(OFF_IRQ_ST);
    chk(d[EV_RET_ERR], 1'b1);
    rd(OFF_INSV);
    chk(d, 16'h0001);
    instr(IK_SPECIAL);
    nmi(1'b0);
    wait_for(1, 2);
    chk(ok, 1'b0);
    wait_for(1, 2);
    chk(ok, 1'b1);
    repeat (4) @(posedge ref_clk);
    instr(IK_IRET);
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_vec();
    t_cs();
    t_nmi();
    t_halt();
    end_of_test();
  end

  initial begin
    #400000;
    n_mismatch++;
    end_of_test();
  end
endmodule
